//--- rtl/vpc_pkg.sv
// Constants, types and helpers of the interrupt priority configuration block
// Function
// - Word A holds fault and timer4..timer0 priorities at 30:28 down to 10:8.
// - Word A holds soft interrupt priority at 6:4; bits 3:0 reserved.
// - Word B holds twowire0 master, sync serial, async serial, converter at 30:16.
// - Word B holds nvm block1, nvm block0 at 14:8, supply monitor 2:0.
// - Word C holds pulse width and external lines 3..0 at 30:28 to 14:12.
// - Word D holds logic arrays 1,0 and external lines 5,4; 31:15 reserved.
// - Control bit 0 enables nesting and priority levels of normal interrupts.
// - Control bit 1 enables nesting and priority levels of fast interrupts.
// - With enables clear, interrupts still reach the core, levels ignored.
// - In default state a pending fast interrupt beats a pending normal one.
// - A set nesting status bit blocks that level and all lower levels.
// - With nesting on, each type nests up to eight levels; fast does not hold normal off.
package vpc_pkg;
  // ----------------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------------
  localparam logic [31:0] ADDR_SET_A = 32'hFFFF0020;
  localparam logic [31:0] ADDR_SET_B = 32'hFFFF0024;
  localparam logic [31:0] ADDR_SET_C = 32'hFFFF0028;
  localparam logic [31:0] ADDR_SET_D = 32'hFFFF002C;
  localparam logic [31:0] ADDR_NEST_CTRL = 32'hFFFF0030;
  localparam logic [31:0] MASK_SET_A = 32'h77777770;
  localparam logic [31:0] MASK_SET_B = 32'h77777707;
  localparam logic [31:0] MASK_SET_C = 32'h77777777;
  localparam logic [31:0] MASK_SET_D = 32'h00007777;
  localparam logic [31:0] MASK_NEST_CTRL = 32'h00000003;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam int NORMAL_EN_BIT = 0;
  localparam int FAST_EN_BIT = 1;
  // ----------------------------------------------------------------------
  // Sources and levels
  // ----------------------------------------------------------------------
  localparam int NUM_SRC = 26;
  localparam int LVL_W = 3;
  localparam int SRC_W = 5;
  localparam int NEST_W = 8;
  localparam logic [LVL_W-1:0] LVL_TOP = 3'h0;
  localparam logic [LVL_W-1:0] LVL_BOTTOM = 3'h7;
  // Word holding each source's field, and the field's low bit
  localparam int SRC_WORD [NUM_SRC] = '{0, 0, 0, 0, 0, 0, 0, 1, 1, 1, 1, 1, 1,
    1, 2, 2, 2, 2, 2, 2, 2, 2, 3, 3, 3, 3};
  localparam int SRC_LSB [NUM_SRC] = '{28, 24, 20, 16, 12, 8, 4, 28, 24, 20, 16,
    12, 8, 0, 28, 24, 20, 16, 12, 8, 4, 0, 12, 8, 4, 0};
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  typedef enum logic [2:0] {
    VPC_SEL_NONE = 3'b000,
    VPC_SEL_A = 3'b001,
    VPC_SEL_B = 3'b010,
    VPC_SEL_C = 3'b011,
    VPC_SEL_D = 3'b100,
    VPC_SEL_CTRL = 3'b101
  } vpc_sel_t;

  // Status bits that block a source of the given level
  function automatic logic [NEST_W-1:0] vpc_block_mask(input logic [LVL_W-1:0] lvl);
    logic [NEST_W:0] ones;
    ones = (9'h001 << ({6'h00, lvl} + 9'h001)) - 9'h001;
    return ones[NEST_W-1:0];
  endfunction

  function automatic vpc_sel_t vpc_decode(input logic [31:0] addr);
    case (addr)
      ADDR_SET_A: return VPC_SEL_A;
      ADDR_SET_B: return VPC_SEL_B;
      ADDR_SET_C: return VPC_SEL_C;
      ADDR_SET_D: return VPC_SEL_D;
      ADDR_NEST_CTRL: return VPC_SEL_CTRL;
      default: return VPC_SEL_NONE;
    endcase
  endfunction
endpackage

//--- rtl/vpc_arbiter.sv
// Picks the winning pending source of one interrupt type
`timescale 1ns/10ps
module vpc_arbiter
  import vpc_pkg::*;
(
  input wire logic [NUM_SRC-1:0] pending,
  input wire logic [NUM_SRC*LVL_W-1:0] levels,
  input wire logic nest_enable,
  input wire logic [NEST_W-1:0] nest_status,
  output logic win_any,
  output logic [SRC_W-1:0] win_src,
  output logic [LVL_W-1:0] win_level
);

  always_comb
  begin
    logic [LVL_W-1:0] lvl;
    logic [LVL_W-1:0] eff;
    logic allowed;
    lvl = LVL_TOP;
    eff = LVL_TOP;
    allowed = 1'b0;
    win_any = 1'b0;
    win_src = '0;
    win_level = LVL_TOP;
    for (int i = 0; i < NUM_SRC; i++)
    begin
      lvl = levels[i*LVL_W +: LVL_W];
      allowed = pending[i] && (!nest_enable || ((nest_status & vpc_block_mask(lvl)) == '0));
      eff = nest_enable ? lvl : LVL_TOP;
      if (allowed && (!win_any || (eff < win_level)))
      begin
        win_any = 1'b1;
        win_src = SRC_W'(i);
        win_level = eff;
      end
    end
  end

endmodule

//--- rtl/vpc_priority_config.sv
// Priority and nesting configuration registers with per-type arbitration
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/10ps
module vpc_priority_config
  import vpc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [1:0] hresp,
  output logic [31:0] hrdata,
  input wire logic [NUM_SRC-1:0] normal_pending,
  input wire logic [NUM_SRC-1:0] fast_pending,
  input wire logic [NEST_W-1:0] normal_nest_status,
  input wire logic [NEST_W-1:0] fast_nest_status,
  output logic [NUM_SRC*LVL_W-1:0] src_levels,
  output logic normal_nest_enable,
  output logic fast_nest_enable,
  output logic normal_irq,
  output logic [SRC_W-1:0] normal_src,
  output logic [LVL_W-1:0] normal_level,
  output logic fast_irq,
  output logic [SRC_W-1:0] fast_src,
  output logic [LVL_W-1:0] fast_level
);

  // ----------------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------------
  logic [31:0] set_a_reg;
  logic [31:0] set_b_reg;
  logic [31:0] set_c_reg;
  logic [31:0] set_d_reg;
  logic [31:0] nesting_control_reg;
  logic [31:0] set_a_next;
  logic [31:0] set_b_next;
  logic [31:0] set_c_next;
  logic [31:0] set_d_next;
  logic [31:0] nesting_control_next;
  logic wr_pend_reg;
  vpc_sel_t wr_sel_reg;
  logic [31:0] hrdata_reg;
  logic [31:0] rd_next;
  logic accept;
  vpc_sel_t addr_sel;

  assign hreadyout = 1'b1;
  assign hresp = HRESP_OKAY;
  assign hrdata = hrdata_reg;
  assign accept = hsel && hready && (htrans == HTRANS_NONSEQ);
  assign addr_sel = vpc_decode(haddr);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      wr_sel_reg <= VPC_SEL_NONE;
    end
    else if (hready)
    begin
      wr_pend_reg <= accept && hwrite;
      wr_sel_reg <= addr_sel;
    end
  end

  // Write data lands at the end of the data phase; reserved bits masked off
  always_comb
  begin
    set_a_next = set_a_reg;
    set_b_next = set_b_reg;
    set_c_next = set_c_reg;
    set_d_next = set_d_reg;
    nesting_control_next = nesting_control_reg;
    if (wr_pend_reg)
    begin
      case (wr_sel_reg)
        VPC_SEL_A: set_a_next = hwdata & MASK_SET_A;
        VPC_SEL_B: set_b_next = hwdata & MASK_SET_B;
        VPC_SEL_C: set_c_next = hwdata & MASK_SET_C;
        VPC_SEL_D: set_d_next = hwdata & MASK_SET_D;
        VPC_SEL_CTRL: nesting_control_next = hwdata & MASK_NEST_CTRL;
        default: set_a_next = set_a_reg;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      set_a_reg <= RESET_WORD;
      set_b_reg <= RESET_WORD;
      set_c_reg <= RESET_WORD;
      set_d_reg <= RESET_WORD;
      nesting_control_reg <= RESET_WORD;
    end
    else
    begin
      set_a_reg <= set_a_next;
      set_b_reg <= set_b_next;
      set_c_reg <= set_c_next;
      set_d_reg <= set_d_next;
      nesting_control_reg <= nesting_control_next;
    end
  end

  // Read mux looks at next values so a back-to-back read sees the write
  always_comb
  begin
    case (addr_sel)
      VPC_SEL_A: rd_next = set_a_next;
      VPC_SEL_B: rd_next = set_b_next;
      VPC_SEL_C: rd_next = set_c_next;
      VPC_SEL_D: rd_next = set_d_next;
      VPC_SEL_CTRL: rd_next = nesting_control_next;
      default: rd_next = RESET_WORD;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_reg <= RESET_WORD;
    else if (accept && !hwrite)
      hrdata_reg <= rd_next;
  end

  // ----------------------------------------------------------------------
  // Field unpacking
  // ----------------------------------------------------------------------
  logic [31:0] prio_words [4];

  assign prio_words[0] = set_a_reg;
  assign prio_words[1] = set_b_reg;
  assign prio_words[2] = set_c_reg;
  assign prio_words[3] = set_d_reg;
  assign normal_nest_enable = nesting_control_reg[NORMAL_EN_BIT];
  assign fast_nest_enable = nesting_control_reg[FAST_EN_BIT];

  for (genvar i = 0; i < NUM_SRC; i++)
  begin : g_field
    assign src_levels[i*LVL_W +: LVL_W] = prio_words[SRC_WORD[i]][SRC_LSB[i] +: LVL_W];
  end

  // ----------------------------------------------------------------------
  // Arbitration per type
  // ----------------------------------------------------------------------
  logic n_any;
  logic [SRC_W-1:0] n_src;
  logic [LVL_W-1:0] n_lvl;
  logic f_any;
  logic [SRC_W-1:0] f_src;
  logic [LVL_W-1:0] f_lvl;
  logic both_off;
  logic normal_irq_reg;
  logic [SRC_W-1:0] normal_src_reg;
  logic [LVL_W-1:0] normal_level_reg;
  logic fast_irq_reg;
  logic [SRC_W-1:0] fast_src_reg;
  logic [LVL_W-1:0] fast_level_reg;

  vpc_arbiter u_normal_arb (
    .pending(normal_pending),
    .levels(src_levels),
    .nest_enable(normal_nest_enable),
    .nest_status(normal_nest_status),
    .win_any(n_any),
    .win_src(n_src),
    .win_level(n_lvl)
  );

  vpc_arbiter u_fast_arb (
    .pending(fast_pending),
    .levels(src_levels),
    .nest_enable(fast_nest_enable),
    .nest_status(fast_nest_status),
    .win_any(f_any),
    .win_src(f_src),
    .win_level(f_lvl)
  );

  assign both_off = !normal_nest_enable && !fast_nest_enable;

  // Fast request holds normal off in default state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      normal_irq_reg <= 1'b0;
      normal_src_reg <= '0;
      normal_level_reg <= LVL_TOP;
    end
    else
    begin
      normal_irq_reg <= n_any && !(both_off && f_any);
      normal_src_reg <= n_src;
      normal_level_reg <= n_lvl;
    end
  end

  // Fast type stays independent of normal nesting
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      fast_irq_reg <= 1'b0;
      fast_src_reg <= '0;
      fast_level_reg <= LVL_TOP;
    end
    else
    begin
      fast_irq_reg <= f_any;
      fast_src_reg <= f_src;
      fast_level_reg <= f_lvl;
    end
  end

  assign normal_irq = normal_irq_reg;
  assign normal_src = normal_src_reg;
  assign normal_level = normal_level_reg;
  assign fast_irq = fast_irq_reg;
  assign fast_src = fast_src_reg;
  assign fast_level = fast_level_reg;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  sequence s_write(logic [31:0] addr);
    accept && hwrite && (haddr == addr) ##1 1'b1;
  endsequence

  sequence s_read(logic [31:0] addr);
    accept && !hwrite && (haddr == addr) && !wr_pend_reg ##1 1'b1;
  endsequence

  chk_write_set_a: assert property (
    s_write(ADDR_SET_A) |=> set_a_reg == ($past(hwdata) & MASK_SET_A))
    else $error("word A write not stored");

  chk_soft_field: assert property (
    s_write(ADDR_SET_A) |=> (set_a_reg[3:0] == 4'h0)
      && (src_levels[6*LVL_W +: LVL_W] == $past(hwdata[6:4])))
    else $error("soft interrupt field wrong");

  chk_write_set_b: assert property (
    s_write(ADDR_SET_B) |=> src_levels[10*LVL_W +: LVL_W] == $past(hwdata[18:16]))
    else $error("converter field wrong");

  chk_supply_field: assert property (
    s_write(ADDR_SET_B) |=> (src_levels[13*LVL_W +: LVL_W] == $past(hwdata[2:0]))
      && (set_b_reg[7:3] == 5'h00))
    else $error("supply monitor field wrong");

  chk_ext_field: assert property (
    s_write(ADDR_SET_C) |=> src_levels[18*LVL_W +: LVL_W] == $past(hwdata[14:12]))
    else $error("external line 0 field wrong");

  chk_twowire_field: assert property (
    s_write(ADDR_SET_C) |=> src_levels[21*LVL_W +: LVL_W] == $past(hwdata[2:0]))
    else $error("twowire0 slave field wrong");

  chk_write_set_d: assert property (
    s_write(ADDR_SET_D) |=> set_d_reg == ($past(hwdata) & MASK_SET_D))
    else $error("word D write not stored");

  chk_ctrl_mask: assert property (
    s_write(ADDR_NEST_CTRL) |=> nesting_control_reg == ($past(hwdata) & MASK_NEST_CTRL))
    else $error("control write not masked");

  chk_read_back: assert property (
    s_read(ADDR_SET_D) |-> hrdata_reg == set_d_reg && (hrdata_reg & ~MASK_SET_D) == '0)
    else $error("read data wrong");

  chk_normal_block: assert property (
    normal_irq_reg && normal_nest_enable && $stable(nesting_control_reg)
      |-> ($past(normal_nest_status) & vpc_block_mask(normal_level_reg)) == '0)
    else $error("blocked normal level raised");

  chk_fast_block: assert property (
    fast_nest_enable && fast_nest_status[0] ##1 fast_nest_enable |-> !fast_irq_reg)
    else $error("fast raised while top level nested");

  chk_plain_raise: assert property (
    both_off && (normal_pending != '0) && (fast_pending == '0) |=> normal_irq_reg)
    else $error("normal not raised in default state");

  chk_fast_first: assert property (
    both_off && (fast_pending != '0) |=> !normal_irq_reg && fast_irq_reg)
    else $error("fast did not take precedence");

  chk_lowest_index: assert property (
    !normal_nest_enable && normal_pending[0] |=> normal_src_reg == '0)
    else $error("lowest index not chosen");

  chk_level_ignored: assert property (
    !normal_nest_enable && $past(!normal_nest_enable) && normal_irq_reg
      |-> normal_level_reg == LVL_TOP)
    else $error("level used while nesting off");

  chk_fast_enable: assert property (
    !fast_nest_enable && (fast_pending != '0) |=> fast_irq_reg && fast_level_reg == LVL_TOP)
    else $error("fast arbitration wrong while off");

  chk_fast_level_block: assert property (
    fast_irq_reg && fast_nest_enable && $stable(nesting_control_reg)
      |-> ($past(fast_nest_status) & vpc_block_mask(fast_level_reg)) == '0)
    else $error("blocked fast level raised");

  chk_fast_lowest: assert property (
    !fast_nest_enable && fast_pending[0] |=> fast_src_reg == '0)
    else $error("lowest fast index not chosen");

  chk_nest_raise: assert property (
    normal_nest_enable && (normal_nest_status == '0) && (normal_pending != '0)
      |=> normal_irq_reg)
    else $error("normal not raised with nothing nested");

  chk_normal_idle: assert property (
    (normal_pending == '0) |=> !normal_irq_reg)
    else $error("normal raised with nothing pending");

  chk_fast_idle: assert property (
    (fast_pending == '0) |=> !fast_irq_reg)
    else $error("fast raised with nothing pending");

endmodule

//--- tb/vpc_src_model.sv
// Far-side interrupt sources and nesting-status logic driving the block
`timescale 1ns/10ps
module vpc_src_model
  import vpc_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic [NUM_SRC-1:0] cmd_normal,
  input wire logic [NUM_SRC-1:0] cmd_fast,
  input wire logic [NEST_W-1:0] cmd_normal_stat,
  input wire logic [NEST_W-1:0] cmd_fast_stat,
  output logic [NUM_SRC-1:0] normal_pending,
  output logic [NUM_SRC-1:0] fast_pending,
  output logic [NEST_W-1:0] normal_nest_status,
  output logic [NEST_W-1:0] fast_nest_status
);
  // --------------------------------------------------------------------
  // Level requests, launched one edge after the command
  // --------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      normal_pending <= '0;
      fast_pending <= '0;
      normal_nest_status <= '0;
      fast_nest_status <= '0;
    end
    else
    begin
      normal_pending <= cmd_normal;
      fast_pending <= cmd_fast;
      normal_nest_status <= cmd_normal_stat;
      fast_nest_status <= cmd_fast_stat;
    end
  end
endmodule

//--- tb/tb_top.sv
// Register and arbitration testbench of the priority configuration block
`timescale 1ns/10ps
module tb_top
  import vpc_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, hresp;
  logic [2:0] hsize;
  wire hready;
  logic hreadyout, n_en, f_en, n_irq, f_irq;
  logic [SRC_W-1:0] n_src, f_src;
  logic [LVL_W-1:0] n_lvl, f_lvl;
  logic [NUM_SRC*LVL_W-1:0] src_levels;
  logic [NUM_SRC-1:0] c_n, c_f, n_pend, f_pend;
  logic [NEST_W-1:0] c_ns, c_fs, n_stat, f_stat;
  logic [31:0] addrs [5] = '{ADDR_SET_A, ADDR_SET_B, ADDR_SET_C, ADDR_SET_D, ADDR_NEST_CTRL};
  logic [31:0] masks [5] = '{MASK_SET_A, MASK_SET_B, MASK_SET_C, MASK_SET_D, 32'h00000003};
  logic [31:0] pat [4] = '{32'h76543210, 32'h12345605, 32'h34567123, 32'h00006543};
  int miscompares = 0;
  int cmp_count = 0;
  assign hready = hreadyout;
  vpc_src_model i_model (.hclk(hclk), .hresetn(hresetn), .cmd_normal(c_n), .cmd_fast(c_f),
    .cmd_normal_stat(c_ns), .cmd_fast_stat(c_fs), .normal_pending(n_pend),
    .fast_pending(f_pend), .normal_nest_status(n_stat), .fast_nest_status(f_stat));
  vpc_priority_config i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .normal_pending(n_pend),
    .fast_pending(f_pend), .normal_nest_status(n_stat), .fast_nest_status(f_stat),
    .src_levels(src_levels), .normal_nest_enable(n_en), .fast_nest_enable(f_en),
    .normal_irq(n_irq), .normal_src(n_src), .normal_level(n_lvl), .fast_irq(f_irq),
    .fast_src(f_src), .fast_level(f_lvl));
  // --------------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------------
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1)
    begin
      n++;
      if (n > 50)
      begin
        miscompares++;
        $display("MISMATCH t=%0t bus wait ran out", $time);
        summarize();
      end
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= wr;
    wait_ready();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
    chk({30'h0, hresp}, {30'h0, HRESP_OKAY}, "response");
  endtask
  // Commands the sources, then waits model edge plus the one registered cycle
  task automatic drive(input logic [25:0] np, input logic [25:0] fp,
    input logic [7:0] ns, input logic [7:0] fs);
    @(posedge hclk);
    c_n <= np;
    c_f <= fp;
    c_ns <= ns;
    c_fs <= fs;
    repeat (2) @(posedge hclk);
    #1;
  endtask
  task automatic arb(input logic fast, input logic e_irq, input logic [4:0] e_src,
    input logic [2:0] e_lvl);
    logic [8:0] got;
    got = fast ? {f_irq, f_src, f_lvl} : {n_irq, n_src, n_lvl};
    if (e_irq)
      chk({23'h0, got}, {23'h0, 1'b1, e_src, e_lvl}, "winner");
    else
      chk({31'h0, got[8]}, 32'h0, "request idle");
  endtask
  initial
  begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  // --------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------
  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    c_n = '0;
    c_f = '0;
    c_ns = '0;
    c_fs = '0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b0, addrs[i], 32'h0);
      chk(rd, RESET_WORD, "reset value");
    end
    $display("test reset_values done");
    for (int i = 0; i < 5; i++)
    begin
      xfer(1'b1, addrs[i], (i == 4) ? 32'h00000003 : 32'hFFFFFFFF);
      xfer(1'b0, addrs[i], 32'h0);
      chk(rd, masks[i], "reserved bits");
    end
    for (int i = 0; i < 4; i++)
      xfer(1'b1, addrs[i], pat[i]);
    xfer(1'b1, ADDR_NEST_CTRL, 32'h0);
    #1;
    for (int i = 0; i < NUM_SRC; i++)
      chk({29'h0, src_levels[3*i+:3]}, (pat[SRC_WORD[i]] >> SRC_LSB[i]) & 32'h7,
        "source level");
    xfer(1'b1, ADDR_NEST_CTRL + 32'h4, 32'hFFFFFFFF);
    xfer(1'b0, ADDR_NEST_CTRL + 32'h4, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    xfer(1'b0, ADDR_SET_C, 32'h0);
    chk(rd, pat[2], "pattern kept");
    $display("test field_map done");
    xfer(1'b1, ADDR_NEST_CTRL, 32'h1);
    #1;
    chk({30'h0, f_en, n_en}, 32'h1, "normal enable");
    xfer(1'b1, ADDR_NEST_CTRL, 32'h2);
    #1;
    chk({30'h0, f_en, n_en}, 32'h2, "fast enable");
    xfer(1'b1, ADDR_NEST_CTRL, 32'h0);
    drive(26'h408, 26'h0, 8'h00, 8'h00);
    arb(1'b0, 1'b1, 5'd3, 3'd0);
    drive(26'h408, 26'h20, 8'hFF, 8'h00);
    arb(1'b0, 1'b0, 5'd0, 3'd0);
    arb(1'b1, 1'b1, 5'd5, 3'd0);
    drive(26'h409, 26'h0, 8'h00, 8'h00);
    arb(1'b0, 1'b1, 5'd0, 3'd0);
    drive(26'h409, 26'h21, 8'h00, 8'h00);
    arb(1'b1, 1'b1, 5'd0, 3'd0);
    arb(1'b0, 1'b0, 5'd0, 3'd0);
    $display("test no_nesting done");
    xfer(1'b1, ADDR_NEST_CTRL, 32'h1);
    drive(26'h408, 26'h0, 8'h00, 8'h00);
    arb(1'b0, 1'b1, 5'd3, 3'd4);
    xfer(1'b1, ADDR_SET_B, 32'h12325605);
    drive(26'h408, 26'h0, 8'h08, 8'h00);
    arb(1'b0, 1'b1, 5'd10, 3'd2);
    drive(26'h408, 26'h0, 8'h04, 8'h00);
    arb(1'b0, 1'b0, 5'd0, 3'd0);
    drive(26'h008, 26'h0, 8'h08, 8'h00);
    arb(1'b0, 1'b0, 5'd0, 3'd0);
    $display("test normal_nesting done");
    xfer(1'b1, ADDR_NEST_CTRL, 32'h2);
    drive(26'h008, 26'h20, 8'h00, 8'h04);
    arb(1'b1, 1'b0, 5'd0, 3'd0);
    arb(1'b0, 1'b1, 5'd3, 3'd0);
    drive(26'h008, 26'h20, 8'h00, 8'h08);
    arb(1'b1, 1'b1, 5'd5, 3'd2);
    drive(26'h008, 26'h2, 8'h00, 8'h80);
    arb(1'b1, 1'b1, 5'd1, 3'd6);
    drive(26'h008, 26'h1, 8'h00, 8'h80);
    arb(1'b1, 1'b0, 5'd0, 3'd0);
    $display("test fast_nesting done");
    summarize();
  end
endmodule
